// file: hw/dd_door_port.sv
`timescale 1ns/1ps
`include "dd_regs.svh"

// How it works
// - Every frame carries one sixteen-bit word each way.
// - Serial output changes on rising serial clock edges while selected.
// - Status word leaves most significant bit first.
// - Serial output is not driven while chip select is high.
// - Serial input is sampled on falling serial clock edges while selected.
// - Control word arrives least significant bit first and is assembled so.
// - Clock and data are ignored unless chip select is low.
// - A floating chip select counts as deselected.
// - Inhibit low or floating puts the block to sleep.
// - Direct drive A gates the high-side switches picked in word one.
// - Direct drive B gates every switch picked in word three that drive A does not take.
// - Sense route follows the serially written sense select bits.
// - Control word is taken in while status goes out, same frame.
// - Asleep, all switches are off and the serial port is dead.
// - Inhibit release clears stored data and tristates power outputs.
module dd_door_port (
  input  wire logic                   clk,             // 50 MHz system clock
  input  wire logic                   rst_n,           // Async reset, active low
  input  wire logic                   sleep_inhibit_n, // Low or floating: sleep
  input  wire logic                   direct_drive_a,  // Direct drive input A
  input  wire logic                   direct_drive_b,  // Direct drive input B
  input  wire logic                   sck,             // Serial clock from master
  input  wire logic                   select_n,        // Chip select, active low
  input  wire logic                   serial_in,       // Serial data from master
  input  dd_pkg::dd_word_t            status_word,     // Diagnosis word to report
  output logic                        serial_out,      // Serial data to master
  output logic                        serial_out_oe,   // High while driving serial_out
  output dd_pkg::dd_sw_t              switch_on_q,     // Per-switch on command
  output logic                        power_out_en_q,  // Low: power outputs tristate
  output logic [`DD_SENSE_W-1:0]      sense_route_q,   // Current sense mux route
  output logic                        sleep_q          // High while asleep
);

  logic [`DD_CTRL_W-1:0] ctrl_one_q;
  dd_pkg::dd_sw_t        sw_state_q;
  dd_pkg::dd_sw_t        drive_b_select;
  logic                  word_valid;
  dd_pkg::dd_word_t      word_data;

  // Decode one address field against a register address
  function automatic logic addr_hit(input dd_pkg::dd_word_t w, input dd_pkg::dd_addr_t a);
    addr_hit = (w[`DD_ADDR_MSB:`DD_ADDR_LSB] == a);
  endfunction

  wire                   sleep_d   = ~sleep_inhibit_n;
  wire                   wake      = sleep_q & sleep_inhibit_n;
  wire                   awake     = ~sleep_q;
  wire                   wr_one    = word_valid & addr_hit(word_data, `DD_ADDR_ONE);
  wire                   wr_two    = word_valid & addr_hit(word_data, `DD_ADDR_TWO);
  wire                   wr_three  = word_valid & addr_hit(word_data, `DD_ADDR_THREE);
  wire [`DD_NHS-1:0]     drive_a_select   = ctrl_one_q[`DD_NHS-1:0];
  wire [`DD_SENSE_W-1:0] sense_mux_select =
    ctrl_one_q[`DD_SENSE_LSB +: `DD_SENSE_W];
  wire [`DD_SENSE_W-1:0] sense_route_d = awake ? sense_mux_select : '0;
  dd_pkg::dd_sw_t        switch_on_d;

  dd_serial_port u_port (
    .clk           (clk),
    .rst_n         (rst_n),
    .enable        (awake),
    .sck           (sck),
    .select_n      (select_n),
    .serial_in     (serial_in),
    .status_word   (status_word),
    .serial_out    (serial_out),
    .serial_out_oe (serial_out_oe),
    .word_valid    (word_valid),
    .word_data     (word_data)
  );

  // Direct drive A reaches only the high-side switches
  genvar gi;
  generate
    for (gi = 0; gi < `DD_NSW; gi = gi + 1) begin : g_sw
      wire sel_a;
      wire level;
      if (gi >= `DD_HS_FIRST) begin : g_hs
        assign sel_a = drive_a_select[gi-`DD_HS_FIRST];
      end else begin : g_ls
        assign sel_a = 1'b0;
      end
      assign level = sel_a ? direct_drive_a :
                     drive_b_select[gi] ? direct_drive_b :
                     sw_state_q[gi];
      assign switch_on_d[gi] = awake & power_out_en_q & level;
    end
  endgenerate

  // Registers clear on inhibit release, not on entry to sleep: the
  // release edge is the one that must leave a clean state behind
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_q        <= 1'b1;
      ctrl_one_q     <= 12'h000;
      sw_state_q     <= 11'h000;
      drive_b_select <= 11'h000;
      power_out_en_q <= 1'b0;
      switch_on_q    <= 11'h000;
      sense_route_q  <= 3'h0;
    end else begin
      sleep_q       <= sleep_d;
      switch_on_q   <= switch_on_d;
      sense_route_q <= sense_route_d;
      if (wake) begin
        ctrl_one_q     <= 12'h000;
        sw_state_q     <= 11'h000;
        drive_b_select <= 11'h000;
        power_out_en_q <= 1'b0;
      end else begin
        if (wr_one) begin
          ctrl_one_q <= word_data[`DD_CTRL_W-1:0];
        end
        if (wr_two) begin
          sw_state_q <= word_data[`DD_NSW-1:0];
        end
        if (wr_three) begin
          drive_b_select <= word_data[`DD_NSW-1:0];
        end
        if (wr_one | wr_two | wr_three) begin
          power_out_en_q <= 1'b1;
        end
      end
    end
  end

  AST_DOUT_ON_RISE: assert property (@(posedge clk) disable iff (!rst_n)
    (serial_out_oe && $past(serial_out_oe) && $changed(serial_out))
      |-> $past(sck) && !$past(sck, 2))
    else $error("Serial output changed without a rising serial clock");

  AST_MSB_FIRST: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(serial_out_oe) |-> serial_out == $past(status_word[`DD_WORD_W-1]))
    else $error("First status bit is not the most significant one");

  AST_DESELECT_Z: assert property (@(posedge clk) disable iff (!rst_n)
    select_n [*2] |-> !serial_out_oe)
    else $error("Serial output driven while deselected");

  AST_SLEEP_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    !sleep_inhibit_n [*2] |=> switch_on_q == '0 && !serial_out_oe && sense_route_q == '0)
    else $error("Switch or serial output active in sleep");

  AST_SLEEP_ENTRY: assert property (@(posedge clk) disable iff (!rst_n)
    !sleep_inhibit_n |=> sleep_q)
    else $error("Inhibit low did not enter sleep");

  AST_WAKE_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    (sleep_q && sleep_inhibit_n) |=> !power_out_en_q && ctrl_one_q == '0
      && sw_state_q == '0 && drive_b_select == '0)
    else $error("Inhibit release did not clear stored data");

  AST_DRIVE_A: assert property (@(posedge clk) disable iff (!rst_n)
    (awake && power_out_en_q && drive_a_select[0])
      |=> switch_on_q[`DD_HS_FIRST] == $past(direct_drive_a))
    else $error("Drive A did not steer its selected high-side switch");

  AST_DRIVE_B: assert property (@(posedge clk) disable iff (!rst_n)
    (awake && power_out_en_q && drive_b_select[0])
      |=> switch_on_q[0] == $past(direct_drive_b))
    else $error("Drive B did not steer its selected switch");

  AST_SENSE_ROUTE: assert property (@(posedge clk) disable iff (!rst_n)
    awake |=> sense_route_q == $past(sense_mux_select))
    else $error("Sense route does not follow the select bits");

  AST_WORD_APPLY: assert property (@(posedge clk) disable iff (!rst_n)
    (word_valid && addr_hit(word_data, `DD_ADDR_ONE) && !wake)
      |=> ctrl_one_q == $past(word_data[`DD_CTRL_W-1:0]))
    else $error("Received word one was not stored");

  AST_WRITE_STATE: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_two && !wake) |=> sw_state_q == $past(word_data[`DD_NSW-1:0]))
    else $error("Received word two was not stored");

  AST_WRITE_DRIVE_B: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_three && !wake) |=> drive_b_select == $past(word_data[`DD_NSW-1:0]))
    else $error("Received word three was not stored");

  // Unknown addresses must leave every stored bit as it was
  AST_ADDR_IGNORE: assert property (@(posedge clk) disable iff (!rst_n)
    (word_valid && !wr_one && !wr_two && !wr_three && !wake)
      |=> $stable(ctrl_one_q) && $stable(sw_state_q) && $stable(drive_b_select))
    else $error("Word with an unknown address changed stored data");

  AST_POWER_ON: assert property (@(posedge clk) disable iff (!rst_n)
    ((wr_one || wr_two || wr_three) && !wake) |=> power_out_en_q)
    else $error("Applied word did not enable the power outputs");

  AST_POWER_GATE: assert property (@(posedge clk) disable iff (!rst_n)
    !power_out_en_q |=> switch_on_q == '0)
    else $error("Switch on while power outputs are tristate");

  AST_SLEEP_HELD: assert property (@(posedge clk) disable iff (!rst_n)
    sleep_q |=> switch_on_q == '0 && sense_route_q == '0)
    else $error("Switch or sense route active while asleep");

  AST_WAKE_SOURCE: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(sleep_q) |-> $past(sleep_inhibit_n))
    else $error("Left sleep without inhibit high");

  // Every high-side switch picked for drive A, not only the first one
  AST_DRIVE_A_ALL: assert property (@(posedge clk) disable iff (!rst_n)
    (awake && power_out_en_q)
      |=> ((switch_on_q[`DD_NSW-1:`DD_HS_FIRST] ^ {`DD_NHS{$past(direct_drive_a)}})
        & $past(drive_a_select)) == '0)
    else $error("A switch picked for drive A did not follow it");

  // Drive A wins, so only switches it leaves alone must follow drive B
  AST_DRIVE_B_ALL: assert property (@(posedge clk) disable iff (!rst_n)
    (awake && power_out_en_q)
      |=> ((switch_on_q ^ {`DD_NSW{$past(direct_drive_b)}}) & $past(drive_b_select)
        & ~{$past(drive_a_select), 6'h00}) == '0)
    else $error("A switch picked for drive B did not follow it");

  AST_STATIC_STATE: assert property (@(posedge clk) disable iff (!rst_n)
    (awake && power_out_en_q)
      |=> ((switch_on_q ^ $past(sw_state_q)) & ~$past(drive_b_select)
        & ~{$past(drive_a_select), 6'h00}) == '0)
    else $error("An unpicked switch did not follow its stored state");

endmodule

// file: inc/dd_regs.svh
`ifndef DD_REGS_SVH
`define DD_REGS_SVH

`define DD_WORD_W     16
`define DD_CNT_W      5
`define DD_CNT_FULL   5'h10
`define DD_CNT_OVER   5'h11
`define DD_ADDR_MSB   15
`define DD_ADDR_LSB   12
`define DD_ADDR_ONE   4'h1
`define DD_ADDR_TWO   4'h2
`define DD_ADDR_THREE 4'h3
`define DD_NSW        11
`define DD_HS_FIRST   6
`define DD_NHS        5
`define DD_SENSE_LSB  5
`define DD_SENSE_W    3
`define DD_CTRL_W     12

`endif

// file: inc/dd_pkg.sv
`include "dd_regs.svh"

package dd_pkg;
  typedef enum logic {
    FR_IDLE,
    FR_ACTIVE
  } dd_frame_e;
  typedef logic [`DD_WORD_W-1:0]                  dd_word_t;
  typedef logic [`DD_ADDR_MSB-`DD_ADDR_LSB:0]     dd_addr_t;
  typedef logic [`DD_NSW-1:0]                     dd_sw_t;
endpackage

// file: hw/dd_serial_port.sv
`timescale 1ns/1ps
`include "dd_regs.svh"

module dd_serial_port (
  input  wire logic        clk,           // System clock
  input  wire logic        rst_n,         // Async reset, active low
  input  wire logic        enable,        // Low while asleep
  input  wire logic        sck,           // Serial clock from master
  input  wire logic        select_n,      // Chip select, active low
  input  wire logic        serial_in,     // Serial data from master
  input  dd_pkg::dd_word_t status_word,   // Status to shift out
  output logic             serial_out,    // Serial data to master
  output logic             serial_out_oe, // High while driving serial_out
  output logic             word_valid,    // One-cycle pulse, word_data good
  output dd_pkg::dd_word_t word_data      // Received control word
);

  dd_pkg::dd_frame_e     state_q;
  logic                  sel_q;
  logic                  sck_q;
  logic [`DD_CNT_W-1:0]  cnt_q;
  dd_pkg::dd_word_t      rx_q;
  dd_pkg::dd_word_t      tx_q;

  wire active   = (state_q == dd_pkg::FR_ACTIVE);
  wire sck_rise = ~sck_q & sck;
  wire sck_fall = sck_q & ~sck;
  wire start    = ~active & enable & sel_q & ~select_n;
  wire stop     = active & (select_n | ~enable);
  wire len_ok   = (cnt_q == `DD_CNT_FULL);
  wire shift_tx = active & sck_rise & (cnt_q != '0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q       <= dd_pkg::FR_IDLE;
      sel_q         <= 1'b1;
      sck_q         <= 1'b0;
      cnt_q         <= '0;
      rx_q          <= 16'h0000;
      tx_q          <= 16'h0000;
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
      word_valid    <= 1'b0;
      word_data     <= 16'h0000;
    end else begin
      sel_q      <= select_n;
      sck_q      <= sck;
      word_valid <= 1'b0;
      if (start) begin
        state_q       <= dd_pkg::FR_ACTIVE;
        tx_q          <= status_word;
        serial_out    <= status_word[`DD_WORD_W-1];
        serial_out_oe <= 1'b1;
        cnt_q         <= '0;
      end else if (stop) begin
        state_q       <= dd_pkg::FR_IDLE;
        serial_out    <= 1'b0;
        serial_out_oe <= 1'b0;
        word_valid    <= enable & len_ok;
        word_data     <= rx_q;
      end else if (active) begin
        if (sck_fall) begin
          rx_q <= {serial_in, rx_q[`DD_WORD_W-1:1]};
          if (cnt_q != `DD_CNT_OVER) begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        if (shift_tx) begin
          // First rising edge keeps the MSB already presented at select
          tx_q       <= {tx_q[`DD_WORD_W-2:0], 1'b0};
          serial_out <= tx_q[`DD_WORD_W-2];
        end
      end
    end
  end

  AST_SAMPLE_FALL: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(rx_q) |-> $past(sck_q) && !$past(sck))
    else $error("Receive shift moved without a falling serial clock");

  AST_LSB_FIRST: assert property (@(posedge clk) disable iff (!rst_n)
    (active && sck_fall && !stop) |=> rx_q[`DD_WORD_W-1] == $past(serial_in))
    else $error("Incoming bit not entered at the top of the shifter");

  AST_LEN_SIXTEEN: assert property (@(posedge clk) disable iff (!rst_n)
    word_valid |-> $past(cnt_q) == `DD_CNT_FULL && $past(select_n))
    else $error("Word applied from a frame that was not sixteen bits");

  AST_IGNORE_DESEL: assert property (@(posedge clk) disable iff (!rst_n)
    select_n [*2] |=> $stable(rx_q) && !word_valid)
    else $error("Shifter moved while deselected");

endmodule

// file: tb/dd_master.sv
`timescale 1ns/1ps

module dd_master (
  input  wire logic clk,        // Bench clock
  input  wire logic serial_out, // Data from device
  output logic      sck,        // Serial clock
  output logic      select_n,   // Chip select, active low
  output logic      serial_in   // Data to device
);
  // Idle levels follow the pin pulls
  initial begin
    sck = 1'b0;
    select_n = 1'b1;
    serial_in = 1'b0;
  end

  // Four clk per phase so edge detection never sits on the margin
  task automatic xfer(input dd_pkg::dd_word_t w, input int n, output dd_pkg::dd_word_t rx);
    rx = '0;
    @(negedge clk) select_n = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      sck = 1'b1;
      serial_in = w[i % 16];
      repeat (4) @(negedge clk);
      rx = {rx[14:0], serial_out};
      sck = 1'b0;
      repeat (4) @(negedge clk);
    end
    select_n = 1'b1;
    serial_in = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  // Clock and data wiggle with select high
  task automatic noise();
    repeat (4) begin
      sck = 1'b1;
      serial_in = 1'b1;
      repeat (4) @(negedge clk);
      sck = 1'b0;
      serial_in = 1'b0;
      repeat (4) @(negedge clk);
    end
  endtask
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
`include "dd_regs.svh"

module testbench;
  logic                   clk;
  logic                   rst_n;
  logic                   sleep_inhibit_n;
  logic                   direct_drive_a;
  logic                   direct_drive_b;
  logic                   sck;
  logic                   select_n;
  logic                   serial_in;
  logic                   serial_out;
  logic                   serial_out_oe;
  logic                   power_out_en_q;
  logic                   sleep_q;
  logic [`DD_SENSE_W-1:0] sense_route_q;
  dd_pkg::dd_sw_t         switch_on_q;
  dd_pkg::dd_word_t       stat;
  dd_pkg::dd_word_t       rx;
  int                     fails;
  int                     n_tests;

  // Data line is pulled high: an undriven line reads 1, opposite to the idle 0,
  // so a frame that the device does not answer cannot look like a real one
  dd_master m (.clk(clk), .serial_out(serial_out_oe ? serial_out : 1'b1), .sck(sck),
    .select_n(select_n), .serial_in(serial_in));

  dd_door_port dut (.clk(clk), .rst_n(rst_n), .sleep_inhibit_n(sleep_inhibit_n),
    .direct_drive_a(direct_drive_a), .direct_drive_b(direct_drive_b), .sck(sck),
    .select_n(select_n), .serial_in(serial_in), .status_word(stat),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe), .switch_on_q(switch_on_q),
    .power_out_en_q(power_out_en_q), .sense_route_q(sense_route_q), .sleep_q(sleep_q));

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_word(input dd_pkg::dd_word_t got, input dd_pkg::dd_word_t exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (fails == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  function automatic dd_pkg::dd_word_t sw();
    return {5'h00, switch_on_q};
  endfunction

  task automatic t_static();
    m.xfer(16'h25A5, 16, rx);
    chk_word(rx, 16'hC3A5);
    chk_word(sw(), 16'h05A5);
    chk_bit(power_out_en_q, 1'b1);
    chk_bit(serial_out_oe, 1'b0);
  endtask

  // Short and long frames must leave the switches alone
  task automatic t_length();
    m.xfer(16'h27FF, 15, rx);
    chk_word(sw(), 16'h05A5);
    m.xfer(16'h27FF, 17, rx);
    chk_word(sw(), 16'h05A5);
    m.noise();
    chk_bit(serial_out_oe, 1'b0);
    chk_word(sw(), 16'h05A5);
  endtask

  task automatic t_drive();
    m.xfer(16'h2000, 16, rx);
    m.xfer(16'h1065, 16, rx);
    chk_word({13'h0000, sense_route_q}, 16'h0003);
    m.xfer(16'h3003, 16, rx);
    direct_drive_a = 1'b1;
    repeat (2) @(negedge clk);
    chk_word(sw(), 16'h0140);
    direct_drive_a = 1'b0;
    direct_drive_b = 1'b1;
    repeat (2) @(negedge clk);
    chk_word(sw(), 16'h0003);
    direct_drive_b = 1'b0;
    direct_drive_a = 1'b1;
  endtask

  // Wake must not restore what was written before sleep
  task automatic t_sleep();
    sleep_inhibit_n = 1'b0;
    repeat (3) @(negedge clk);
    chk_bit(sleep_q, 1'b1);
    chk_word(sw(), 16'h0000);
    m.xfer(16'h27FF, 16, rx);
    chk_word(rx, 16'hFFFF);
    sleep_inhibit_n = 1'b1;
    repeat (4) @(negedge clk);
    chk_bit(sleep_q, 1'b0);
    chk_word(sw(), 16'h0000);
    chk_bit(power_out_en_q, 1'b0);
    direct_drive_a = 1'b0;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    #500000;
    fails++;
    test_done();
  end

  initial begin
    fails = 0;
    n_tests = 0;
    rst_n = 1'b0;
    sleep_inhibit_n = 1'b1;
    direct_drive_a = 1'b0;
    direct_drive_b = 1'b0;
    stat = 16'hC3A5;
    repeat (4) @(negedge clk);
    chk_bit(sleep_q, 1'b1);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk_bit(power_out_en_q, 1'b0);
    t_static();
    t_length();
    t_drive();
    t_sleep();
    test_done();
  end
endmodule
